// file: hdl/lpi_cfg.svh
// command codes and timing for the indicator / power save command logic
// assumes one 10 MHz clock; included by the top module only, not by the package
`ifndef LPI_CFG_SVH
`define LPI_CFG_SVH
`define LPI_CMD_IND_OFF   8'hac
`define LPI_CMD_IND_ON    8'had
`define LPI_CMD_SAVE_SBY  8'ha8
`define LPI_CMD_SAVE_SLP  8'ha9
`define LPI_CMD_SAVE_EXIT 8'he1
`define LPI_CMD_REV_SET   4'h3
`define LPI_CMD_REV_RST   8'he4
`define LPI_CMD_OSC_ON    8'hab
`define LPI_CMD_NOP       8'he3
`define LPI_CMD_RESET     8'he2
`define LPI_CMD_TEST      4'hf
`define LPI_IND_RST       2'h0
`define LPI_REV_RST       4'h0
`define LPI_CLK_HZ        10000000
`define LPI_HALF_SEC_MS   500
`define LPI_ONE_SEC_MS    1000
`endif

// file: hdl/lpi_pkg.sv
// types for the indicator / power save command logic
// assumes nothing beyond the config header
package lpi_pkg;
  typedef enum logic [2:0] {
    LPI_RUN  = 3'b001,
    LPI_SBY  = 3'b010,
    LPI_SLP  = 3'b100
  } lpi_pwr_t;
  typedef enum logic [1:0] {
    LPI_IND_OFF   = 2'h0,
    LPI_IND_SLOW  = 2'h1,
    LPI_IND_FAST  = 2'h2,
    LPI_IND_STEADY = 2'h3
  } lpi_ind_t;
endpackage : lpi_pkg

// file: hdl/lpi_cmd_logic.sv
// single-byte command decoder for indicator, power save, reversal, osc
// assumes host write strobe is one cycle, synchronous to CLK
//
// Summary of operation
// - indicator set stores two low bits
// - indicator code selects off/blink/steady
// - power save bit0: standby or sleep
// - low power keeps settings and ram access
// - sleep halts oscillator and supply
// - sleep drives segments/commons to supply
// - standby halts supply, oscillator runs
// - standby stops duty drive, indicator runs
// - blanking output low in low power
// - exit restores previous operating state
// - reversal set loads four-bit line count
// - reversal reset keeps stored count
// - osc start needs master and internal select
// - test mode entered by 0xf? byte
// - after indicator on only register set
// - reset command reinitialises indicator, test
`timescale 1ns/10ps
`default_nettype none
`include "lpi_cfg.svh"
module lpi_cmd_logic
  import lpi_pkg::*;
#(
  parameter int CLK_HZ = `LPI_CLK_HZ
)(
  // clock and reset
  input  wire logic       CLK,
  input  wire logic       RST_N,
  // host write port
  input  wire logic       WR_STB,
  input  wire logic       CMD_DATA_SELECT,
  input  wire logic [7:0] DATA_IN,
  // straps
  input  wire logic       MASTER_SELECT,
  input  wire logic       INTERNAL_OSC_SELECT,
  // outputs
  output logic            DISPLAY_BLANK_OUT,
  output logic            OSC_RUN,
  output logic            SUPPLY_RUN,
  output logic            DUTY_DRIVE_RUN,
  output logic            OUTPUTS_AT_SUPPLY,
  output logic            INDICATOR_OUT,
  output logic            NLINE_ACTIVE,
  output logic [3:0]      REVERSAL_LINE_COUNT,
  output logic            TEST_MODE
);
  localparam int HALF_CYC = CLK_HZ / 1000 * `LPI_HALF_SEC_MS / 2;
  localparam int ONE_CYC  = CLK_HZ / 1000 * `LPI_ONE_SEC_MS / 2;
  // divider reloads on the compare, so each half period is exactly
  // HALF_CYC or ONE_CYC cycles; 24 bits cover a 10 MHz clock
  // limitation: a much faster clock needs a wider divider

  lpi_pwr_t   pwr_reg, pwr_next;
  lpi_ind_t   ind_reg, ind_next;
  logic [3:0] rev_reg, rev_next;
  logic       nline_reg, nline_next;
  logic       ind_wait_reg, ind_wait_next;
  logic       osc_on_reg, osc_on_next;
  logic       test_reg, test_next;
  logic [23:0] div_reg, div_next;
  logic       tog_reg, tog_next;
  logic       ind_out_next;
  logic       cmd;

  assign cmd = WR_STB && !CMD_DATA_SELECT;

  always_comb
  begin
    pwr_next      = pwr_reg;
    ind_next      = ind_reg;
    rev_next      = rev_reg;
    nline_next    = nline_reg;
    ind_wait_next = ind_wait_reg;
    osc_on_next   = osc_on_reg;
    test_next     = test_reg;
    if (cmd)
    begin
      if (ind_wait_reg)
      begin
        // only register set
        // hazard: any byte here is data, a reset command too,
        // so a lost data byte leaves the pair open
        // two low bits
        ind_next      = lpi_ind_t'(DATA_IN[1:0]);
        ind_wait_next = 1'b0;
      end
      else if (DATA_IN[7:4] == `LPI_CMD_TEST)
      begin
        test_next = 1'b1;
      end
      else if (DATA_IN[7:4] == `LPI_CMD_REV_SET)
      begin
        rev_next   = DATA_IN[3:0];
        nline_next = 1'b1;
      end
      else
      begin
        case (DATA_IN)
          `LPI_CMD_IND_ON:    ind_wait_next = 1'b1;
          `LPI_CMD_IND_OFF:   ind_next = LPI_IND_OFF;
          `LPI_CMD_SAVE_SBY:  pwr_next = LPI_SBY;
          `LPI_CMD_SAVE_SLP:  pwr_next = LPI_SLP;
          // settings untouched, so exit restores them
          `LPI_CMD_SAVE_EXIT: pwr_next = LPI_RUN;
          `LPI_CMD_REV_RST:   nline_next = 1'b0;
          `LPI_CMD_OSC_ON:
          begin
            if (MASTER_SELECT && INTERNAL_OSC_SELECT)
              osc_on_next = 1'b1;
          end
          `LPI_CMD_NOP:       test_next = 1'b0;
          `LPI_CMD_RESET:
          begin
            ind_next  = lpi_ind_t'(`LPI_IND_RST);
            test_next = 1'b0;
          end
          default:            ;
        endcase
      end
    end
  end

  // blink from oscillator; halted only in sleep
  always_comb
  begin
    div_next = div_reg;
    tog_next = tog_reg;
    if (pwr_reg != LPI_SLP)
    begin
      if (ind_reg == LPI_IND_SLOW ? div_reg >= 24'(HALF_CYC - 1)
                                  : div_reg >= 24'(ONE_CYC - 1))
      begin
        div_next = 24'h0;
        tog_next = !tog_reg;
      end
      else
        div_next = div_reg + 24'h1;
    end
    // indicator code decode
    // decoded from next values so the output changes on the same edge as the setting
    // trade-off: blink phase runs free, not restarted per setting
    case (ind_next)
      LPI_IND_OFF:    ind_out_next = 1'b0;
      LPI_IND_SLOW,
      LPI_IND_FAST:   ind_out_next = tog_reg;
      LPI_IND_STEADY: ind_out_next = 1'b1;
      default:        ind_out_next = 1'b0;
    endcase
    if (pwr_next == LPI_SLP)
      ind_out_next = 1'b0;
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pwr_reg      <= LPI_RUN;
      ind_reg      <= lpi_ind_t'(`LPI_IND_RST);
      rev_reg      <= `LPI_REV_RST;
      nline_reg    <= 1'b0;
      ind_wait_reg <= 1'b0;
      osc_on_reg   <= 1'b0;
      test_reg     <= 1'b0;
      div_reg      <= 24'h0;
      tog_reg      <= 1'b0;
      DISPLAY_BLANK_OUT   <= 1'b1;
      OSC_RUN             <= 1'b0;
      SUPPLY_RUN          <= 1'b1;
      DUTY_DRIVE_RUN      <= 1'b1;
      OUTPUTS_AT_SUPPLY   <= 1'b0;
      INDICATOR_OUT       <= 1'b0;
      NLINE_ACTIVE        <= 1'b0;
      REVERSAL_LINE_COUNT <= `LPI_REV_RST;
      TEST_MODE           <= 1'b0;
    end
    else
    begin
      pwr_reg      <= pwr_next;
      ind_reg      <= ind_next;
      rev_reg      <= rev_next;
      nline_reg    <= nline_next;
      ind_wait_reg <= ind_wait_next;
      osc_on_reg   <= osc_on_next;
      test_reg     <= test_next;
      div_reg      <= div_next;
      tog_reg      <= tog_next;
      DISPLAY_BLANK_OUT   <= (pwr_next == LPI_RUN);
      // sleep stops oscillator; standby keeps it
      // start request survives sleep so exit brings it back
      OSC_RUN             <= osc_on_next && (pwr_next != LPI_SLP);
      SUPPLY_RUN          <= (pwr_next == LPI_RUN);
      // duty drive stopped, outputs at supply
      DUTY_DRIVE_RUN      <= (pwr_next == LPI_RUN);
      OUTPUTS_AT_SUPPLY   <= (pwr_next != LPI_RUN);
      INDICATOR_OUT       <= ind_out_next;
      NLINE_ACTIVE        <= nline_next;
      REVERSAL_LINE_COUNT <= rev_next;
      TEST_MODE           <= test_next;
    end
  end
endmodule : lpi_cmd_logic
`default_nettype wire

// file: bench/lpi_cmd_sva.sv
// checker: command outcomes at the ports of lpi_cmd_logic
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module lpi_cmd_sva (
  input wire logic       CLK, RST_N, WR_STB, CMD_DATA_SELECT,
  input wire logic [7:0] DATA_IN,
  input wire logic       DISPLAY_BLANK_OUT, OSC_RUN, SUPPLY_RUN,
  input wire logic       DUTY_DRIVE_RUN, OUTPUTS_AT_SUPPLY, INDICATOR_OUT,
  input wire logic       NLINE_ACTIVE, TEST_MODE,
  input wire logic [3:0] REVERSAL_LINE_COUNT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire logic tk = WR_STB && !CMD_DATA_SELECT;
  logic pend_reg, pend_next;
  // the byte after indicator on is data, never a command
  always_comb pend_next = tk ? !pend_reg && DATA_IN == 8'had : pend_reg;
  always_ff @(posedge CLK) pend_reg <= RST_N && pend_next;
  wire logic cm = tk && !pend_reg;
  sequence op(logic [7:0] c);
    cm && DATA_IN == c;
  endsequence
  a_sleep_state: assert property (op(8'ha9) |=> !DISPLAY_BLANK_OUT &&
    !OSC_RUN && !SUPPLY_RUN && !DUTY_DRIVE_RUN && OUTPUTS_AT_SUPPLY)
    else $error("sleep");
  a_exit_restore: assert property (op(8'ha9) ##0 DUTY_DRIVE_RUN
    ##1 op(8'he1) |=> DISPLAY_BLANK_OUT && OSC_RUN == $past(OSC_RUN, 2))
    else $error("restore");
  a_ind_pair: assert property (tk && pend_reg && DUTY_DRIVE_RUN &&
    DATA_IN[0] == DATA_IN[1] |=> INDICATOR_OUT == $past(DATA_IN[0]))
    else $error("ind");
  a_rev_load: assert property (cm && DATA_IN[7:4] == 4'h3 |=> NLINE_ACTIVE &&
    REVERSAL_LINE_COUNT == $past(DATA_IN[3:0])) else $error("rev");
  a_rev_reset: assert property (op(8'he4) |=> !NLINE_ACTIVE &&
    $stable(REVERSAL_LINE_COUNT)) else $error("rev rst");
  a_test_enter: assert property (cm && DATA_IN[7:4] == 4'hf |=> TEST_MODE)
    else $error("test");
  a_test_exit: assert property ((op(8'he2) or op(8'he3)) |=> !TEST_MODE)
    else $error("test off");
  a_data_inert: assert property (WR_STB && CMD_DATA_SELECT |=>
    $stable({OSC_RUN, NLINE_ACTIVE, TEST_MODE, DUTY_DRIVE_RUN}))
    else $error("inert");
endmodule : lpi_cmd_sva
bind lpi_cmd_logic lpi_cmd_sva chk_u (.*);
`default_nettype wire

// file: bench/lpi_host.sv
// host model: writes one byte per call on the parallel port
// assumes calls start right after a rising CLK edge
`timescale 1ns/10ps
`default_nettype none
module lpi_host (
  input wire logic   CLK,
  output logic       WR_STB,
  output logic       CMD_DATA_SELECT,
  output logic [7:0] DATA_IN
);
  initial {WR_STB, CMD_DATA_SELECT, DATA_IN} = 10'h000;
  task put(input logic s, input logic [7:0] d);
    WR_STB <= 1'b1;
    CMD_DATA_SELECT <= s;
    DATA_IN <= d;
    @(posedge CLK);
  endtask : put
  // released bus flips so a stale byte is never read as valid
  task idle;
    WR_STB <= 1'b0;
    DATA_IN <= ~DATA_IN;
    @(posedge CLK);
  endtask : idle
endmodule : lpi_host
`default_nettype wire

// file: bench/lpi_cmd_logic_tb_top.sv
// bench: host model sends command bytes, outputs are compared
// assumes CLK_HZ 1000, so blink half periods are 250 and 500 cycles
`timescale 1ns/10ps
`default_nettype none
module lpi_cmd_logic_tb_top;
  logic CLK = 0, RST_N = 0, MASTER_SELECT = 0, INTERNAL_OSC_SELECT = 0;
  logic WR_STB, CMD_DATA_SELECT, DISPLAY_BLANK_OUT, OSC_RUN, SUPPLY_RUN;
  logic DUTY_DRIVE_RUN, OUTPUTS_AT_SUPPLY, INDICATOR_OUT, NLINE_ACTIVE;
  logic TEST_MODE;
  logic [7:0] DATA_IN;
  logic [3:0] REVERSAL_LINE_COUNT;
  int num_errors = 0, check_count = 0, cyc = 0, n;
  wire logic [4:0] pw = {DISPLAY_BLANK_OUT, SUPPLY_RUN, DUTY_DRIVE_RUN,
    OUTPUTS_AT_SUPPLY, OSC_RUN};
  always #50 CLK = ~CLK;
  lpi_host host_u (.*);
  lpi_cmd_logic #(.CLK_HZ(1000)) dut_u (.*);
  task chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task cmd(input logic [7:0] d);
    host_u.put(1'b0, d);
    host_u.idle;
  endtask : cmd
  // {blank, supply, duty, at_supply, osc}; standby keeps osc running
  function logic [15:0] pwr(input logic [7:0] c);
    return c == 8'ha8 ? 16'h03 : c == 8'ha9 ? 16'h02 : 16'h1d;
  endfunction : pwr
  always @(posedge CLK)
    if (++cyc == 20000)
    begin
      num_errors++;
      wrap_up;
    end
  initial
  begin
    n = $urandom(48715);
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    chk({pw, INDICATOR_OUT, NLINE_ACTIVE, TEST_MODE}, 16'he0);
    for (int k = 0; k < 4; k++)
    begin
      {MASTER_SELECT, INTERNAL_OSC_SELECT} <= 2'(k);
      cmd(8'hab);
      chk(OSC_RUN, k == 3);
    end
    host_u.put(1'b0, 8'had);
    cmd(8'($urandom) | 8'h03);
    chk(INDICATOR_OUT, 1);
    host_u.put(1'b0, 8'had);
    cmd(8'hf0);
    chk({INDICATOR_OUT, TEST_MODE}, 0);
    for (int k = 1; k < 3; k++)
    begin
      host_u.put(1'b0, 8'had);
      cmd(8'(k));
      if (k == 2) cmd(8'ha8);
      repeat (2) @(INDICATOR_OUT);
      n = cyc;
      @(INDICATOR_OUT);
      chk(cyc - n, 250 * k);
    end
    cmd(8'he1);
    for (int k = 0; k < 2; k++)
    begin
      cmd(8'ha8 + 8'(k));
      chk(pw, pwr(8'ha8 + 8'(k)));
      host_u.put(1'b0, 8'ha8 + 8'(k));
      cmd(8'he1);
      chk(pw, pwr(8'he1));
    end
    for (int k = 0; k < 4; k++)
    begin
      n = k < 2 ? 15 * k : $urandom;
      cmd({4'h3, 4'(n)});
      chk({NLINE_ACTIVE, REVERSAL_LINE_COUNT}, {1'b1, 4'(n)});
      cmd(8'he4);
      chk({NLINE_ACTIVE, REVERSAL_LINE_COUNT}, {1'b0, 4'(n)});
    end
    for (int k = 0; k < 3; k++)
    begin
      cmd(8'hf0 | 8'($urandom));
      host_u.put(1'b1, 8'he3);
      host_u.idle;
      chk(TEST_MODE, 1);
      if (k == 2) RST_N <= 1'b0;
      cmd(k == 0 ? 8'he2 : k == 1 ? 8'he3 : 8'h00);
      RST_N <= 1'b1;
      chk({TEST_MODE, INDICATOR_OUT}, 0);
    end
    wrap_up;
  end
endmodule : lpi_cmd_logic_tb_top
`default_nettype wire
